// >>> hw/isa_bus_cfg.svh
// constants for the isa system bus control block
`ifndef ISA_BUS_CFG_SVH
`define ISA_BUS_CFG_SVH

`define CLK_PERIOD_NS   5
`define CMD_MIN_NS      125
`define CMD_MIN_CYC     ((`CMD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W          26
`define DATA_W          16
`define DACK_W          2
`define CNT_W           8
`define ADDR_RST        26'h0000000
`define DATA_RST        16'h0000

`endif

// >>> hw/isa_bus_pkg.sv
// types shared by the isa system bus control block
package isa_bus_pkg;

	typedef enum logic [3:0] {
		KIND_IO_READ    = 4'h0,
		KIND_IO_WRITE   = 4'h1,
		KIND_MEM        = 4'h2,
		KIND_DMA_IO_RD  = 4'h3,
		KIND_DMA_IO_WR  = 4'h4,
		KIND_DMA_INT    = 4'h5,
		KIND_PCC_IO_RD  = 4'h6,
		KIND_PCC_IO_WR  = 4'h7,
		KIND_PCC_MEM    = 4'h8
	} bus_kind_type;

	typedef struct packed {
		bus_kind_type kind;
		logic [25:0]  addr;
		logic [15:0]  wdata;
		logic         byte_high;
		logic         dack_sel;
	} bus_req_type;

	typedef struct packed {
		logic [15:0] rdata;
		logic        width16;
		logic        waited;
	} bus_resp_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ALE  = 3'b001,
		ST_CMD  = 3'b010,
		ST_WAIT = 3'b011,
		ST_DONE = 3'b100
	} bus_state_type;

endpackage : isa_bus_pkg

// >>> hw/isa_system_bus_control.sv
// isa bus master cycle control: strobes, commands, transceiver and ready handling
`timescale 1ns/1ps
`include "isa_bus_cfg.svh"

module isa_system_bus_control
	import isa_bus_pkg::*;
#(
	parameter int CMD_CYC = `CMD_MIN_CYC
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic         req_valid,
	input  wire bus_req_type  req,
	output logic              req_ready,
	output logic              resp_valid,
	output bus_resp_type      resp,
	input  wire logic         local_bus_mode,
	input  wire logic         dram32_mode,
	input  wire logic         iochrdy_in,
	input  wire logic         iocs16_n,
	input  wire logic         mcs16_n,
	input  wire logic [15:0]  sd_in,
	output logic [15:0]       sd_out,
	output logic              sd_oe,
	output logic [25:0]       sa,
	output logic              aen,
	output logic              bale,
	output logic              sbhe_n,
	output logic              ior_n,
	output logic              iow_n,
	output logic              mem_phase,
	output logic [1:0]        prog_dma_ack_n,
	output logic              xcvr_output_enable_n,
	output logic              xcvr_dir_high_byte,
	output logic              xcvr_dir_low_byte
);

	// loaded one short because the cycle that enters the command phase counts too
	localparam logic [`CNT_W-1:0] CMD_LOAD = `CNT_W'(CMD_CYC - 1);

	bus_state_type    state_r;
	bus_state_type    state_nxt;
	bus_req_type      cur_r;
	logic [`CNT_W-1:0] cnt_r;
	logic [1:0]       rdy_sync_r;
	logic [1:0]       io16_sync_r;
	logic [1:0]       m16_sync_r;
	logic             width16_r;
	logic             waited_r;

	// kind decoding used by several processes
	function automatic logic is_read(input bus_kind_type k);
		is_read = (k == KIND_IO_READ) || (k == KIND_DMA_IO_RD) || (k == KIND_PCC_IO_RD);
	endfunction : is_read

	function automatic logic is_write(input bus_kind_type k);
		is_write = (k == KIND_IO_WRITE) || (k == KIND_DMA_IO_WR) || (k == KIND_PCC_IO_WR);
	endfunction : is_write

	function automatic logic is_dma(input bus_kind_type k);
		is_dma = (k == KIND_DMA_IO_RD) || (k == KIND_DMA_IO_WR) || (k == KIND_DMA_INT);
	endfunction : is_dma

	// strobe-only cycles carry no command and no data phase
	function automatic logic strobe_only(input bus_kind_type k);
		strobe_only = (k == KIND_DMA_INT) || (k == KIND_PCC_MEM);
	endfunction : strobe_only

	function automatic logic uses_xcvr(input bus_kind_type k);
		uses_xcvr = is_read(k) || is_write(k) || (k == KIND_MEM);
	endfunction : uses_xcvr

	// two-flop synchronisers; the first stage feeds only the second
	// a late select or ready edge costs at most two extra cycles of latency
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			// reset reads as ready so no stale low stretches the first cycle
			rdy_sync_r  <= 2'h3;
			io16_sync_r <= 2'h0;
			m16_sync_r  <= 2'h0;
		end else begin
			rdy_sync_r  <= {rdy_sync_r[0], iochrdy_in};
			io16_sync_r <= {io16_sync_r[0], ~iocs16_n};
			m16_sync_r  <= {m16_sync_r[0], ~mcs16_n};
		end
	end

	// channel ready as seen by the state machine, taken after the second stage
	logic rdy_ok;
	assign rdy_ok = rdy_sync_r[1];

	// next state of the cycle sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (req_valid) begin
					state_nxt = ST_ALE;
				end
			end
			ST_ALE: begin
				// strobe-only cycles end right after the latch pulse
				if (strobe_only(cur_r.kind)) begin
					state_nxt = ST_DONE;
				end else begin
					state_nxt = ST_CMD;
				end
			end
			ST_CMD: begin
				if (cnt_r == '0) begin
					state_nxt = rdy_ok ? ST_DONE : ST_WAIT;
				end
			end
			ST_WAIT: begin
				// no limit: a device that holds ready low stalls the bus for good
				if (rdy_ok) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// request capture and handshake; ready drops the edge a request is taken
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cur_r     <= '0;
			req_ready <= 1'b1;
		end else if (state_r == ST_IDLE && req_valid) begin
			cur_r     <= req;
			req_ready <= 1'b0;
		end else if (state_r == ST_DONE) begin
			req_ready <= 1'b1;
		end
	end

	// command width counter, then open-ended wait on channel ready
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (state_r == ST_ALE) begin
			cnt_r <= CMD_LOAD;
		end else if (state_r == ST_CMD && cnt_r != '0) begin
			cnt_r <= cnt_r - `CNT_W'(1);
		end
	end

	// width decision at the end of the minimum command time, so the
	// synchronised select has settled even for a late-driving device
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			width16_r <= 1'b0;
			waited_r  <= 1'b0;
		end else if (state_r == ST_IDLE && req_valid) begin
			// cleared at the take edge, not the latch edge: a strobe-only cycle
			// reports from the latch state and must not see the last cycle's flags
			width16_r <= 1'b0;
			waited_r  <= 1'b0;
		end else if (state_r == ST_CMD && cnt_r == '0) begin
			if (cur_r.kind == KIND_MEM) begin
				width16_r <= m16_sync_r[1];
			end else begin
				width16_r <= io16_sync_r[1];
			end
			waited_r <= ~rdy_ok;
		end
	end

	// address, latch strobe and byte high enable
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sa     <= `ADDR_RST;
			bale   <= 1'b0;
			sbhe_n <= 1'b1;
		end else if (state_r == ST_IDLE && req_valid) begin
			sa     <= req.addr;
			bale   <= 1'b1;
			sbhe_n <= ~req.byte_high;
		end else begin
			bale <= 1'b0;
			if (state_r == ST_DONE) begin
				sbhe_n <= 1'b1;
			end
		end
	end

	// address enable covers the whole dma or pc card io cycle, so io
	// decoders on the isa side stay quiet for the full command time
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			aen <= 1'b0;
		end else if (state_r == ST_IDLE && req_valid) begin
			aen <= is_dma(req.kind)
				|| (req.kind == KIND_PCC_IO_RD) || (req.kind == KIND_PCC_IO_WR);
		end else if (state_r == ST_DONE) begin
			aen <= 1'b0;
		end
	end

	// dma acknowledge picks the single io device allowed into a dma cycle
	// only two acknowledge lines exist, so dack_sel is a single bit
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prog_dma_ack_n <= 2'h3;
		end else if (state_r == ST_IDLE && req_valid
			&& (req.kind == KIND_DMA_IO_RD || req.kind == KIND_DMA_IO_WR)) begin
			prog_dma_ack_n <= req.dack_sel ? 2'h1 : 2'h2;
		end else if (state_r == ST_DONE) begin
			prog_dma_ack_n <= 2'h3;
		end
	end

	// io commands after the latch pulse, held through wait states
	// the command drops on the edge entering done, a cycle before address
	// enable and acknowledge go, so devices see them outlast the command
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ior_n     <= 1'b1;
			iow_n     <= 1'b1;
			mem_phase <= 1'b0;
		end else if (state_r == ST_ALE) begin
			ior_n     <= ~is_read(cur_r.kind);
			iow_n     <= ~is_write(cur_r.kind);
			mem_phase <= (cur_r.kind == KIND_MEM);
		end else if (state_nxt == ST_DONE) begin
			ior_n     <= 1'b1;
			iow_n     <= 1'b1;
			mem_phase <= 1'b0;
		end
	end

	// write data is driven with the command from the end of the latch pulse until a cycle after the command ends,
	// which covers the whole window in which a device may latch it
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sd_out <= `DATA_RST;
			sd_oe  <= 1'b0;
		end else if (state_r == ST_ALE && is_write(cur_r.kind)) begin
			sd_out <= cur_r.wdata;
			sd_oe  <= 1'b1;
		end else if (state_r == ST_DONE) begin
			sd_oe  <= 1'b0;
		end
	end

	// external transceiver control, only in the buffered bus modes;
	// the enable is raised one cycle after direction to avoid contention
	// direction is left as it was after a cycle; only the enable drops, so
	// the transceiver never turns round while it could still be driving
	logic buffered;
	assign buffered = local_bus_mode | dram32_mode;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			xcvr_output_enable_n <= 1'b1;
			xcvr_dir_high_byte   <= 1'b0;
			xcvr_dir_low_byte    <= 1'b0;
		end else if (!buffered) begin
			xcvr_output_enable_n <= 1'b1;
			xcvr_dir_high_byte   <= 1'b0;
			xcvr_dir_low_byte    <= 1'b0;
		end else if (state_r == ST_IDLE && req_valid) begin
			xcvr_dir_high_byte <= is_read(req.kind);
			xcvr_dir_low_byte  <= is_read(req.kind);
		end else if (state_r == ST_ALE) begin
			xcvr_output_enable_n <= ~uses_xcvr(cur_r.kind);
		end else if (state_r == ST_DONE) begin
			xcvr_output_enable_n <= 1'b1;
		end
	end

	// response: read data is captured while the read command still stands
	// non-read kinds return zero so stale bus values never reach the caller
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			resp_valid <= 1'b0;
			resp       <= '0;
		end else if (state_nxt == ST_DONE && state_r != ST_DONE) begin
			resp_valid    <= 1'b1;
			resp.rdata    <= is_read(cur_r.kind) ? sd_in : `DATA_RST;
			resp.width16  <= (state_r == ST_CMD) ? ((cur_r.kind == KIND_MEM) ?
				m16_sync_r[1] : io16_sync_r[1]) : width16_r;
			resp.waited   <= (state_r == ST_WAIT) | waited_r;
		end else begin
			resp_valid <= 1'b0;
		end
	end

endmodule : isa_system_bus_control

// >>> test/isa_bus_monitor.sv
// assertion checker for the isa bus control block
`timescale 1ns/1ps

module isa_bus_monitor
	import isa_bus_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic         rstn,
	input wire logic         req_valid,
	input wire bus_req_type  req,
	input wire logic         req_ready,
	input wire logic         resp_valid,
	input wire bus_resp_type resp,
	input wire logic         local_bus_mode,
	input wire logic         dram32_mode,
	input wire logic         iochrdy_in,
	input wire logic [15:0]  sd_in,
	input wire logic         sd_oe,
	input wire logic         aen,
	input wire logic         bale,
	input wire logic         ior_n,
	input wire logic         iow_n,
	input wire logic [1:0]   prog_dma_ack_n,
	input wire logic         xcvr_output_enable_n,
	input wire logic         xcvr_dir_high_byte,
	input wire logic         xcvr_dir_low_byte
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// a request accepted, and the tail of an on-chip dma cycle
	sequence s_take; req_valid && req_ready; endsequence
	sequence s_int_tail; aen ##1 resp_valid; endsequence

	property p_bale_once; s_take |=> bale ##1 !bale; endproperty
	property p_int; s_take and req.kind == KIND_DMA_INT |=> s_int_tail; endproperty
	property p_ack_aen; prog_dma_ack_n != 2'b11 |-> aen; endproperty
	// five low cycles cover the two-stage ready synchroniser
	property p_stretch; (!iochrdy_in && !(ior_n && iow_n))[*5] |=> !resp_valid; endproperty
	property p_rd_data; resp_valid && !$past(ior_n) |-> resp.rdata == $past(sd_in); endproperty
	property p_rd_free; !ior_n |-> !sd_oe; endproperty
	property p_wr_drive; !iow_n |-> sd_oe; endproperty
	// buffer controls are registered, so they follow the mode inputs one edge late
	property p_oe_mode;
		!xcvr_output_enable_n |-> $past(local_bus_mode) || $past(dram32_mode);
	endproperty
	property p_dir_mode;
		xcvr_dir_low_byte |-> $past(local_bus_mode) || $past(dram32_mode);
	endproperty
	property p_dir_pair; xcvr_dir_high_byte == xcvr_dir_low_byte; endproperty
	property p_end; resp_valid |=> req_ready && !aen && prog_dma_ack_n == 2'b11; endproperty

	a_bale_once: assert property (p_bale_once) else $error("strobe not one cycle");
	a_int: assert property (p_int) else $error("internal dma cycle wrong");
	a_ack_aen: assert property (p_ack_aen) else $error("ack without aen");
	a_stretch: assert property (p_stretch) else $error("ended while not ready");
	a_rd_data: assert property (p_rd_data) else $error("read data not captured");
	a_rd_free: assert property (p_rd_free) else $error("driving during read");
	a_wr_drive: assert property (p_wr_drive) else $error("no data on write");
	a_oe_mode: assert property (p_oe_mode) else $error("buffer on, no mode");
	a_dir_mode: assert property (p_dir_mode) else $error("dir set, no mode");
	a_dir_pair: assert property (p_dir_pair) else $error("byte dirs differ");
	a_end: assert property (p_end) else $error("cycle not released");
endmodule : isa_bus_monitor

bind isa_system_bus_control isa_bus_monitor mon (.*);

// >>> test/isa_peripheral_model.sv
// behavioural isa peripheral: stretches ready and answers reads
`timescale 1ns/1ps

module isa_peripheral_model (
	input  wire logic        clk_sys,
	input  wire logic        ior_n,
	input  wire logic        iow_n,
	input  wire logic        aen,
	input  wire logic [1:0]  prog_dma_ack_n,
	input  wire logic [3:0]  stall,
	input  wire logic [15:0] rd_val,
	output logic             iochrdy_in,
	output logic [15:0]      sd_in
);
	logic [3:0]  cnt_r;
	logic [15:0] last_r;

	// count command cycles, saturating so a long stall cannot wrap
	always_ff @(posedge clk_sys) begin
		cnt_r  <= (ior_n && iow_n) ? 4'h0 : cnt_r + 4'(cnt_r != 4'hF);
		last_r <= sd_in;
	end
	// isa decode includes address enable; in dma only the acknowledged device joins
	logic isa_sel;
	assign isa_sel = !aen || prog_dma_ack_n != 2'h3;
	// open drain: only a selected isa device pulls low to stretch the command
	assign iochrdy_in = (ior_n && iow_n) || !isa_sel || cnt_r >= stall;
	// the pc card answers its own reads with the inverse; released bus toggles
	assign sd_in = ior_n ? ~last_r : (isa_sel ? rd_val : ~rd_val);
endmodule : isa_peripheral_model

// >>> test/isa_system_bus_control_tb_top.sv
// self-checking bench for the isa bus control block
`timescale 1ns/1ps

module isa_system_bus_control_tb_top;
	import isa_bus_pkg::*;
	logic clk_sys, rstn, req_valid, req_ready, resp_valid, local_bus_mode, dram32_mode;
	logic iochrdy_in, iocs16_n, mcs16_n, sd_oe, aen, bale, sbhe_n, ior_n, iow_n, mem_phase;
	logic xcvr_output_enable_n, xcvr_dir_high_byte, xcvr_dir_low_byte;
	logic [15:0]  sd_in, sd_out, rd_val;
	logic [25:0]  sa;
	logic [1:0]   prog_dma_ack_n;
	logic [3:0]   stall;
	bus_req_type  req;
	bus_resp_type resp;
	bus_req_type  rq_q[$];
	bus_resp_type ex_q[$];
	int           err_count, comparisons;
	logic         bale_seen;

	isa_system_bus_control #(.CMD_CYC(3)) dut (.*);
	isa_peripheral_model model (.*);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [25:0] got, input logic [25:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// offer one request, note what should come back, wait for it
	task automatic do_req(input bus_kind_type k, input logic [3:0] st);
		bus_req_type  r;
		bus_resp_type e;
		logic         w16;
		r = {k, 26'($urandom), 16'($urandom), 1'($urandom), 1'($urandom)};
		w16 = 1'($urandom);
		stall = st;
		rd_val = 16'($urandom);
		{local_bus_mode, dram32_mode} = 2'($urandom);
		iocs16_n = !(w16 && k inside {KIND_IO_READ, KIND_IO_WRITE, KIND_PCC_IO_RD, KIND_PCC_IO_WR});
		mcs16_n = !(w16 && k == KIND_MEM);
		e.rdata = k inside {KIND_IO_READ, KIND_DMA_IO_RD} ? rd_val :
			(k == KIND_PCC_IO_RD ? ~rd_val : 16'h0000);
		e.width16 = !(iocs16_n && mcs16_n);
		e.waited = st != 4'h0 && k inside {KIND_IO_READ, KIND_IO_WRITE, KIND_DMA_IO_RD,
			KIND_DMA_IO_WR};
		rq_q.push_back(r);
		ex_q.push_back(e);
		while (req_ready !== 1'b1)
			@(negedge clk_sys);
		req = r;
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		for (int n = 0; n < 200 && resp_valid !== 1'b1; n++)
			@(negedge clk_sys);
		if (resp_valid !== 1'b1) begin
			err_count++;
			$display("BAD %0t no response kind %0d", $time, k);
		end
		@(negedge clk_sys);
		$display("test done kind %0d stall %0d", k, st);
	endtask : do_req

	// watcher: strobe-time outputs, write data, then the response
	always @(posedge clk_sys) begin
		#1;
		if (bale === 1'b1 && rq_q.size() > 0) begin
			check(26'(aen), 26'(rq_q[0].kind inside {[KIND_DMA_IO_RD:KIND_PCC_IO_WR]}));
			check(26'(prog_dma_ack_n), 26'(rq_q[0].kind inside {KIND_DMA_IO_RD, KIND_DMA_IO_WR}
				? (rq_q[0].dack_sel ? 2'b01 : 2'b10) : 2'b11));
			check(26'(sbhe_n), 26'(!rq_q[0].byte_high));
			check(sa, rq_q[0].addr);
			check(26'(xcvr_dir_low_byte), 26'((local_bus_mode || dram32_mode)
				&& rq_q[0].kind inside {KIND_IO_READ, KIND_DMA_IO_RD, KIND_PCC_IO_RD}));
		end
		// one cycle after the latch pulse: commands, memory phase, buffer enable
		if (bale_seen === 1'b1 && rq_q.size() > 0)
			check(26'({mem_phase, ior_n, iow_n, xcvr_output_enable_n}), 26'({
				rq_q[0].kind == KIND_MEM,
				!(rq_q[0].kind inside {KIND_IO_READ, KIND_DMA_IO_RD, KIND_PCC_IO_RD}),
				!(rq_q[0].kind inside {KIND_IO_WRITE, KIND_DMA_IO_WR, KIND_PCC_IO_WR}),
				!((local_bus_mode || dram32_mode)
				&& !(rq_q[0].kind inside {KIND_DMA_INT, KIND_PCC_MEM}))}));
		if (iow_n === 1'b0 && rq_q.size() > 0)
			check(26'(sd_out), 26'(rq_q[0].wdata));
		if (resp_valid === 1'b1 && ex_q.size() > 0) begin
			if (rq_q[0].kind != KIND_MEM)
				check(26'(resp.rdata), 26'(ex_q[0].rdata));
			check(26'(resp.width16), 26'(ex_q[0].width16));
			check(26'(resp.waited), 26'(ex_q[0].waited));
			void'(rq_q.pop_front());
			void'(ex_q.pop_front());
		end
		bale_seen = (bale === 1'b1);
	end

	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		{local_bus_mode, dram32_mode, iocs16_n, mcs16_n} = 4'h3;
		stall = 4'h0;
		rd_val = 16'h0000;
		void'($urandom(32'h2243360b));
		repeat (4) @(negedge clk_sys);
		rstn = 1'b1;
		// every kind, ready prompt then stall 8, which holds ready low past the minimum command time for the isa and dma io kinds
		for (int rep = 0; rep < 2; rep++)
			for (int k = 0; k < 9; k++)
				do_req(bus_kind_type'(k), rep ? 4'h8 : 4'h0);
		complete_run();
	end

	initial begin
		#20000;
		err_count++;
		complete_run();
	end
endmodule : isa_system_bus_control_tb_top
